//--- verilog/setpoint_limiter_ramp.sv
`timescale 1ns/1ps
module setpoint_limiter_ramp import sp_ramp_pkg::*; #(
    parameter int SP_WIDTH = SP_W
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // process side
    input wire logic signed [SP_WIDTH-1:0] i_pv,
    input wire logic signed [SP_WIDTH-1:0] i_remote_sp,
    input wire logic signed [SP_WIDTH-1:0] i_range_upper,
    input wire logic signed [SP_WIDTH-1:0] i_range_lower,
    input wire logic i_input_cfg_change,
    input wire logic i_error,
    input wire logic i_sec_tick,
    // set point consumers
    output logic signed [SP_WIDTH-1:0] o_ctrl_sp,
    output logic signed [SP_WIDTH-1:0] o_alarm_sp,
    output logic o_ramping,
    output logic o_autotune_start
);
    typedef struct packed {
        ramp_state_t st;
        logic run;
        logic remote;
        logic alsel;
        logic [BANK_W-1:0] bank;
        logic [1:0] unit;
        logic signed [SP_WIDTH-1:0] local_sp;
        logic signed [SP_WIDTH-1:0] upper;
        logic signed [SP_WIDTH-1:0] lower;
        logic signed [SP_WIDTH-1:0] ramp_sp;
        logic signed [SP_WIDTH-1:0] alarm_sp;
        logic [TICK_W-1:0] tick_cnt;
        logic reapply;
        logic at_pending;
        logic at_start;
        logic ramping;
        logic [31:0] prdata;
    } state_t;

    state_t r;
    state_t n;
    if (SP_WIDTH != SP_W) begin
        $error("setpoint_limiter_ramp: SP_WIDTH must match package width");
    end

    ramp_bank_if #(.W(SP_WIDTH), .IDX_W(BANK_W)) bank_if ();

    bank_ramp_mem #(.W(SP_WIDTH), .DEPTH(BANKS), .IDX_W(BANK_W)) u_bank_mem (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .bus(bank_if.mem)
    );

    logic apb_wr;
    logic apb_rd_setup;
    logic mapped;
    logic run_eff;
    logic unit_hit;
    logic ramping;
    logic within_step;
    logic local_wr;
    logic [SP_WIDTH-1:0] amount;
    logic [TICK_W-1:0] unit_limit;
    logic signed [SP_WIDTH-1:0] src_sp;
    logic signed [SP_WIDTH-1:0] target;
    logic signed [SP_WIDTH-1:0] local_in;
    logic signed [SP_WIDTH-1:0] local_clamped;
    logic signed [SP_WIDTH:0] diff;
    logic signed [SP_WIDTH:0] amt_ext;
    logic signed [SP_WIDTH:0] ramp_ext;

    assign apb_wr = i_psel & i_penable & i_pwrite;
    assign apb_rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign local_wr = apb_wr && (i_paddr == OFF_LOCAL_SP);

    always_comb begin
        case (i_paddr)
            OFF_CTRL, OFF_LOCAL_SP, OFF_UPPER, OFF_LOWER, OFF_UNIT,
            OFF_RAMP_ADJ, OFF_RAMP_BANK, OFF_STATUS, OFF_RAMP_SP, OFF_TARGET: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // zero wait states; unmapped addresses answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    // bank amounts: adjustment path hits the active bank, the bank path any bank
    assign bank_if.wr_en = apb_wr && (i_paddr == OFF_RAMP_ADJ || i_paddr == OFF_RAMP_BANK);
    assign bank_if.wr_idx = (i_paddr == OFF_RAMP_ADJ) ? r.bank
        : i_pwdata[RAMP_BANK_LSB +: BANK_W];
    assign bank_if.wr_data = i_pwdata[SP_WIDTH-1:0];
    assign bank_if.rd_idx = r.bank;
    assign amount = bank_if.rd_data;

    // a fresh local value is clamped on the way in, else re-clamped in place
    assign local_in = local_wr ? $signed(i_pwdata[SP_WIDTH-1:0]) : r.local_sp;

    sp_clamp #(.W(SP_WIDTH)) u_clamp_local (
        .i_value(local_in),
        .i_upper(r.upper),
        .i_lower(r.lower),
        .o_value(local_clamped)
    );

    assign src_sp = r.remote ? i_remote_sp : r.local_sp;

    sp_clamp #(.W(SP_WIDTH)) u_clamp_target (
        .i_value(src_sp),
        .i_upper(r.upper),
        .i_lower(r.lower),
        .o_value(target)
    );

    assign run_eff = r.run & ~i_error;

    always_comb begin
        case (r.unit)
            UNIT_MIN: begin
                unit_limit = UNIT_MIN_TICKS;
            end
            UNIT_HOUR: begin
                unit_limit = UNIT_HOUR_TICKS;
            end
            default: begin
                unit_limit = UNIT_SEC_TICKS;
            end
        endcase
    end

    // one step per time unit keeps the arithmetic free of division
    assign unit_hit = i_sec_tick && (r.tick_cnt >= unit_limit - 1'b1);

    assign ramp_ext = {r.ramp_sp[SP_WIDTH-1], r.ramp_sp};
    assign diff = {target[SP_WIDTH-1], target} - ramp_ext;
    assign amt_ext = $signed({1'b0, amount});
    assign within_step = (diff <= amt_ext) && (diff >= -amt_ext);

    assign ramping = run_eff && ((r.st == ST_SEED) ||
        (r.st == ST_RAMP && amount != RAMP_OFF && r.ramp_sp != target));

    always_comb begin
        n = r;
        n.at_start = 1'b0;
        n.reapply = 1'b0;
        if (r.reapply) begin
            n.local_sp = local_clamped;
        end
        if (r.at_pending && !ramping && run_eff) begin
            n.at_pending = 1'b0;
            n.at_start = 1'b1;
        end

        if (apb_wr) begin
            case (i_paddr)
                OFF_CTRL: begin
                    n.run = i_pwdata[CTRL_RUN_BIT];
                    n.remote = i_pwdata[CTRL_REMOTE_BIT];
                    n.alsel = i_pwdata[CTRL_ALSEL_BIT];
                    n.bank = i_pwdata[CTRL_BANK_LSB +: BANK_W];
                    if (i_pwdata[CTRL_AT_BIT]) begin
                        n.at_pending = 1'b1;
                    end
                    if (i_pwdata[CTRL_REAPPLY_BIT]) begin
                        n.reapply = 1'b1;
                    end
                end
                OFF_LOCAL_SP: begin
                    n.local_sp = local_clamped;
                end
                OFF_UPPER: begin
                    n.upper = $signed(i_pwdata[SP_WIDTH-1:0]);
                    n.reapply = 1'b1;
                end
                OFF_LOWER: begin
                    n.lower = $signed(i_pwdata[SP_WIDTH-1:0]);
                    n.reapply = 1'b1;
                end
                OFF_UNIT: begin
                    n.unit = i_pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // a range change overrides any bound written in the same cycle
        if (i_input_cfg_change) begin
            n.upper = i_range_upper;
            n.lower = i_range_lower;
            n.reapply = 1'b1;
        end
        if (i_sec_tick) begin
            n.tick_cnt = unit_hit ? '0 : r.tick_cnt + 1'b1;
        end
        case (r.st)
            ST_STOP: begin
                n.ramp_sp = target;
                if (run_eff) begin
                    n.st = ST_SEED;
                end
            end
            ST_SEED: begin
                n.ramp_sp = (amount == RAMP_OFF) ? target : i_pv;
                n.tick_cnt = '0;
                n.st = ST_RAMP;
            end
            ST_RAMP: begin
                if (!run_eff) begin
                    n.st = ST_STOP;
                    n.ramp_sp = target;
                end else if (amount == RAMP_OFF) begin
                    n.ramp_sp = target;
                end else if (unit_hit) begin
                    if (within_step) begin
                        n.ramp_sp = target;
                    end else if (diff > 0) begin
                        n.ramp_sp = SP_WIDTH'(ramp_ext + amt_ext);
                    end else begin
                        n.ramp_sp = SP_WIDTH'(ramp_ext - amt_ext);
                    end
                end
            end
            default: begin
                n.st = ST_STOP;
            end
        endcase
        n.alarm_sp = r.alsel ? target : n.ramp_sp;
        n.ramping = ramping;
        if (apb_rd_setup) begin
            n.prdata = '0;
            case (i_paddr)
                OFF_CTRL: begin
                    n.prdata[CTRL_RUN_BIT] = r.run;
                    n.prdata[CTRL_REMOTE_BIT] = r.remote;
                    n.prdata[CTRL_ALSEL_BIT] = r.alsel;
                    n.prdata[CTRL_BANK_LSB +: BANK_W] = r.bank;
                end
                OFF_LOCAL_SP: begin
                    n.prdata = 32'(r.local_sp);
                end
                OFF_UPPER: begin
                    n.prdata = 32'(r.upper);
                end
                OFF_LOWER: begin
                    n.prdata = 32'(r.lower);
                end
                OFF_UNIT: begin
                    n.prdata[1:0] = r.unit;
                end
                OFF_RAMP_ADJ, OFF_RAMP_BANK: begin
                    n.prdata[SP_WIDTH-1:0] = amount;
                end
                OFF_STATUS: begin
                    n.prdata[STAT_RAMPING_BIT] = ramping;
                    n.prdata[STAT_AT_PEND_BIT] = r.at_pending;
                    n.prdata[STAT_AT_RUN_BIT] = r.at_start;
                    n.prdata[STAT_RUNNING_BIT] = run_eff;
                end
                OFF_RAMP_SP: begin
                    n.prdata = 32'(r.ramp_sp);
                end
                OFF_TARGET: begin
                    n.prdata = 32'(target);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
            r.st <= ST_STOP;
            r.run <= RST_RUN;
            r.upper <= RST_UPPER;
            r.lower <= RST_LOWER;
            r.local_sp <= RST_LOCAL_SP;
            r.unit <= RST_UNIT;
        end else begin
            r <= n;
        end
    end

    assign o_prdata = r.prdata;
    assign o_ctrl_sp = r.ramp_sp;
    assign o_alarm_sp = r.alarm_sp;
    assign o_ramping = r.ramping;
    assign o_autotune_start = r.at_start;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_seed;
        r.st == ST_SEED && amount != RAMP_OFF;
    endsequence
    sequence s_last_step;
        r.st == ST_RAMP && run_eff && amount != RAMP_OFF && unit_hit && within_step;
    endsequence
    sequence s_hold_step;
        r.st == ST_RAMP && run_eff && amount != RAMP_OFF && !unit_hit;
    endsequence

    AST_REAPPLY_CLAMP: assert property (
        r.reapply && !apb_wr && !i_input_cfg_change |=> r.local_sp <= r.upper && r.local_sp >= r.lower)
        else $error("local set point left outside bounds after re-apply");
    AST_RANGE_RELOAD: assert property (
        i_input_cfg_change |=> r.upper == $past(i_range_upper) && r.lower == $past(i_range_lower)
            ##1 (r.local_sp <= r.upper && r.local_sp >= r.lower) || $past(apb_wr)
            || $past(i_input_cfg_change))
        else $error("bounds not reloaded from input range");
    AST_STEP_HOLD: assert property (
        s_hold_step |=> $stable(r.ramp_sp))
        else $error("ramp set point moved between unit steps");
    AST_OFF_PASS: assert property (
        r.st == ST_RAMP && run_eff && amount == RAMP_OFF |=> o_ctrl_sp == $past(target))
        else $error("ramp off but set point not passed through");
    AST_SEED_PV: assert property (
        s_seed |=> r.st == ST_RAMP && o_ctrl_sp == $past(i_pv))
        else $error("ramp did not start from process value");
    AST_STOP_NO_RAMP: assert property (
        !run_eff |=> !o_ramping ##1 r.st != ST_RAMP || $past(run_eff))
        else $error("ramping while stopped or in error");
    AST_AT_DEFER: assert property (
        o_autotune_start |-> $past(r.at_pending) && !$past(ramping))
        else $error("auto-tune started during ramp");
    AST_ALARM_REF: assert property (
        !$past(r.alsel) |-> o_alarm_sp == o_ctrl_sp)
        else $error("alarm reference not the ramp set point");
    AST_LAST_STEP: assert property (
        s_last_step |=> o_ctrl_sp == $past(target))
        else $error("ramp did not land on target");
endmodule

//--- common/sp_ramp_pkg.sv
package sp_ramp_pkg;
    localparam int SP_W = 16;
    localparam int BANKS = 8;
    localparam int BANK_W = 3;
    localparam int TICK_W = 12;

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOCAL_SP = 8'h04;
    localparam logic [7:0] OFF_UPPER = 8'h08;
    localparam logic [7:0] OFF_LOWER = 8'h0c;
    localparam logic [7:0] OFF_UNIT = 8'h10;
    localparam logic [7:0] OFF_RAMP_ADJ = 8'h14;
    localparam logic [7:0] OFF_RAMP_BANK = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_RAMP_SP = 8'h20;
    localparam logic [7:0] OFF_TARGET = 8'h24;

    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_REMOTE_BIT = 1;
    localparam int CTRL_ALSEL_BIT = 2;
    localparam int CTRL_BANK_LSB = 4;
    localparam int CTRL_AT_BIT = 8;
    localparam int CTRL_REAPPLY_BIT = 9;
    localparam int RAMP_BANK_LSB = 16;

    // status register fields
    localparam int STAT_RAMPING_BIT = 0;
    localparam int STAT_AT_PEND_BIT = 1;
    localparam int STAT_AT_RUN_BIT = 2;
    localparam int STAT_RUNNING_BIT = 3;

    // reset values
    localparam logic RST_RUN = 1'b1;
    localparam logic [SP_W-1:0] RST_UPPER = 16'h7fff;
    localparam logic [SP_W-1:0] RST_LOWER = 16'h8000;
    localparam logic [SP_W-1:0] RST_LOCAL_SP = 16'h0000;
    localparam logic [SP_W-1:0] RAMP_OFF = 16'h0000;
    localparam logic [1:0] RST_UNIT = 2'h0;

    // ramp time unit codes and their length in second ticks
    localparam logic [1:0] UNIT_SEC = 2'h0;
    localparam logic [1:0] UNIT_MIN = 2'h1;
    localparam logic [1:0] UNIT_HOUR = 2'h2;
    localparam logic [TICK_W-1:0] UNIT_SEC_TICKS = 12'h001;
    localparam logic [TICK_W-1:0] UNIT_MIN_TICKS = 12'h03c;
    localparam logic [TICK_W-1:0] UNIT_HOUR_TICKS = 12'he10;

    typedef enum logic [1:0] {ST_STOP, ST_SEED, ST_RAMP} ramp_state_t;
endpackage

//--- common/ramp_bank_if.sv
`timescale 1ns/1ps
interface ramp_bank_if #(parameter int W = 16, parameter int IDX_W = 3);
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [W-1:0] wr_data;
    logic [IDX_W-1:0] rd_idx;
    logic [W-1:0] rd_data;
    modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
    modport ctl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
endinterface

//--- verilog/sp_clamp.sv
`timescale 1ns/1ps
module sp_clamp #(parameter int W = 16) (
    // value and bounds
    input wire logic signed [W-1:0] i_value,
    input wire logic signed [W-1:0] i_upper,
    input wire logic signed [W-1:0] i_lower,
    // clamped value
    output logic signed [W-1:0] o_value
);
    // with crossed bounds, values above the upper bound get the upper bound, all others the lower bound
    always_comb begin
        if (i_value > i_upper) begin
            o_value = i_upper;
        end else if (i_value < i_lower) begin
            o_value = i_lower;
        end else begin
            o_value = i_value;
        end
    end
endmodule

//--- verilog/bank_ramp_mem.sv
`timescale 1ns/1ps
module bank_ramp_mem #(parameter int W = 16, parameter int DEPTH = 8, parameter int IDX_W = 3) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // access port
    ramp_bank_if.mem bus
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] word;
        logic [W-1:0] rd;
    } mem_state_t;

    mem_state_t r;
    mem_state_t n;

    if (DEPTH > (1 << IDX_W) || W < 1) begin
        $error("bank_ramp_mem: depth does not fit index width");
    end

    always_comb begin
        n = r;
        if (bus.wr_en) begin
            n.word[bus.wr_idx] = bus.wr_data;
        end
        n.rd = r.word[bus.rd_idx];
    end

    // every amount starts as off, so no bank ramps until configured
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.rd_data = r.rd;
endmodule

//--- testbench/sp_consumer_model.sv
`timescale 1ns/1ps
// control loop side: watches the working set point and auto-tune starts
module sp_consumer_model import sp_ramp_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // consumed signals
    input wire logic signed [SP_W-1:0] i_ctrl_sp,
    input wire logic i_autotune_start,
    input wire logic i_clear,
    // observations
    output logic [7:0] o_at_count,
    output logic [SP_W-1:0] o_max_step
);
    logic signed [SP_W-1:0] prev_r;
    logic signed [SP_W-1:0] diff;

    // seeding jumps are not steps, so the bench clears the maximum after seeding
    assign diff = (i_ctrl_sp > prev_r) ? i_ctrl_sp - prev_r : prev_r - i_ctrl_sp;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_r <= '0;
            o_at_count <= 8'h00;
            o_max_step <= '0;
        end else begin
            prev_r <= i_ctrl_sp;
            if (i_autotune_start) begin
                o_at_count <= o_at_count + 8'h01;
            end
            if (i_clear) begin
                o_max_step <= '0;
            end else if (diff > o_max_step) begin
                o_max_step <= diff;
            end
        end
    end
endmodule

//--- testbench/setpoint_limiter_ramp_tb_top.sv
`timescale 1ns/1ps
module setpoint_limiter_ramp_tb_top import sp_ramp_pkg::*;;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic signed [15:0] i_pv = 16'h0000;
    logic signed [15:0] i_remote_sp = 16'h0000;
    logic signed [15:0] i_range_upper = 16'h0000;
    logic signed [15:0] i_range_lower = 16'h0000;
    logic i_input_cfg_change = 1'b0;
    logic i_error = 1'b0;
    logic i_sec_tick = 1'b0;
    logic i_clear = 1'b0;
    logic signed [15:0] o_ctrl_sp;
    logic signed [15:0] o_alarm_sp;
    logic o_ramping;
    logic o_autotune_start;
    logic [7:0] at_count;
    logic [15:0] max_step;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] q;
    logic e;

    always #5 i_core_clk = ~i_core_clk;

    setpoint_limiter_ramp u_setpoint_limiter_ramp (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_pv(i_pv), .i_remote_sp(i_remote_sp), .i_range_upper(i_range_upper),
        .i_range_lower(i_range_lower), .i_input_cfg_change(i_input_cfg_change),
        .i_error(i_error), .i_sec_tick(i_sec_tick), .o_ctrl_sp(o_ctrl_sp),
        .o_alarm_sp(o_alarm_sp), .o_ramping(o_ramping), .o_autotune_start(o_autotune_start));

    sp_consumer_model u_sp_consumer_model (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_ctrl_sp(o_ctrl_sp), .i_autotune_start(o_autotune_start), .i_clear(i_clear),
        .o_at_count(at_count), .o_max_step(max_step));

    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard well above the longest sequence
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        // only the bench timeout ends a wait for the slave
        do begin
            @(posedge i_core_clk);
        end while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check("register read", q, exp);
    endtask

    task automatic ctl(input logic run, input logic rem, input logic al, input int bank,
                       input logic at);
        logic [31:0] d;
        d = 32'h0000_0000;
        d[CTRL_RUN_BIT] = run;
        d[CTRL_REMOTE_BIT] = rem;
        d[CTRL_ALSEL_BIT] = al;
        d[CTRL_BANK_LSB+:BANK_W] = bank[BANK_W-1:0];
        d[CTRL_AT_BIT] = at;
        apb(1'b1, OFF_CTRL, d);
    endtask

    // one second tick per pulse, then let the step land
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            i_sec_tick <= 1'b1;
            @(posedge i_core_clk);
            i_sec_tick <= 1'b0;
        end
        wt(3);
    endtask

    task automatic sp(input logic [15:0] exp);
        check("ctrl_sp", sx(o_ctrl_sp), sx(exp));
    endtask

    initial begin
        wt(6);
        i_rst <= 1'b0;
        rd(OFF_UPPER, 32'h0000_7fff);
        rd(OFF_LOWER, 32'hffff_8000);
        rd(OFF_LOCAL_SP, 32'h0000_0000);
        rd(OFF_UNIT, 32'h0000_0000);
        rd(OFF_RAMP_ADJ, 32'h0000_0000);
        rd(8'h28, 32'h0000_0000);
        check("pslverr", {31'h0, e}, 32'h0000_0001);
        // limiter bounds
        apb(1'b1, OFF_UPPER, 32'h0000_0064);
        apb(1'b1, OFF_LOWER, 32'hffff_ffce);
        apb(1'b1, OFF_LOCAL_SP, 32'h0000_00c8);
        rd(OFF_TARGET, 32'h0000_0064);
        apb(1'b1, OFF_LOCAL_SP, 32'hffff_ff9c);
        rd(OFF_TARGET, 32'hffff_ffce);
        apb(1'b1, OFF_LOCAL_SP, 32'h0000_0050);
        apb(1'b1, OFF_UPPER, 32'h0000_003c);
        wt(2);
        rd(OFF_LOCAL_SP, 32'h0000_003c);
        apb(1'b1, OFF_CTRL, 32'h0000_0201);
        wt(2);
        rd(OFF_LOCAL_SP, 32'h0000_003c);
        rd(OFF_CTRL, 32'h0000_0001);
        // input configuration change reloads the bounds
        i_range_upper <= 16'h01f4;
        i_range_lower <= 16'hfe0c;
        wt(1);
        i_input_cfg_change <= 1'b1;
        wt(1);
        i_input_cfg_change <= 1'b0;
        rd(OFF_UPPER, 32'h0000_01f4);
        rd(OFF_LOWER, 32'hffff_fe0c);
        // ramp off passes steps through
        apb(1'b1, OFF_LOCAL_SP, 32'h0000_012c);
        wt(4);
        sp(16'h012c);
        check("ramping", {31'h0, o_ramping}, 32'h0000_0000);
        // per-bank amounts
        for (int b = 0; b < BANKS; b++) begin
            apb(1'b1, OFF_RAMP_BANK, (b << RAMP_BANK_LSB) | (10 + b));
        end
        for (int b = 0; b < BANKS; b++) begin
            ctl(1'b1, 1'b0, 1'b0, b, 1'b0);
            rd(OFF_RAMP_ADJ, 10 + b);
        end
        ctl(1'b1, 1'b0, 1'b0, 2, 1'b0);
        apb(1'b1, OFF_RAMP_ADJ, 32'h0000_0007);
        rd(OFF_RAMP_BANK, 32'h0000_0007);
        ctl(1'b1, 1'b0, 1'b0, 3, 1'b0);
        rd(OFF_RAMP_ADJ, 32'h0000_000d);
        // upward ramp seeded from the process value, auto-tune held back
        ctl(1'b0, 1'b0, 1'b0, 0, 1'b0);
        apb(1'b1, OFF_LOCAL_SP, 32'h0000_0019);
        i_pv <= 16'h0000;
        ctl(1'b1, 1'b0, 1'b0, 0, 1'b0);
        wt(4);
        sp(16'h0000);
        check("ramping", {31'h0, o_ramping}, 32'h0000_0001);
        i_clear <= 1'b1;
        wt(1);
        i_clear <= 1'b0;
        tick(1);
        sp(16'h000a);
        rd(OFF_RAMP_SP, 32'h0000_000a);
        ctl(1'b1, 1'b0, 1'b0, 0, 1'b1);
        wt(2);
        rd(OFF_STATUS, 32'h0000_000b);
        tick(1);
        sp(16'h0014);
        check("at_count", {24'h0, at_count}, 32'h0000_0000);
        tick(1);
        sp(16'h0019);
        wt(2);
        check("ramping", {31'h0, o_ramping}, 32'h0000_0000);
        check("at_count", {24'h0, at_count}, 32'h0000_0001);
        check("max_step", {16'h0, max_step}, 32'h0000_000a);
        // downward ramp, minute unit, alarm reference select
        apb(1'b1, OFF_UNIT, 32'h0000_0001);
        ctl(1'b0, 1'b0, 1'b0, 1, 1'b0);
        i_pv <= 16'h0064;
        ctl(1'b1, 1'b0, 1'b0, 1, 1'b0);
        wt(4);
        sp(16'h0064);
        tick(59);
        sp(16'h0064);
        tick(1);
        sp(16'h0059);
        ctl(1'b1, 1'b0, 1'b1, 1, 1'b0);
        wt(3);
        check("alarm_sp", sx(o_alarm_sp), 32'h0000_0019);
        ctl(1'b1, 1'b0, 1'b0, 1, 1'b0);
        wt(3);
        check("alarm_sp", sx(o_alarm_sp), 32'h0000_0059);
        // remote switch keeps ramping
        apb(1'b1, OFF_UNIT, 32'h0000_0000);
        i_remote_sp <= 16'hffd8;
        ctl(1'b1, 1'b1, 1'b0, 1, 1'b0);
        wt(2);
        rd(OFF_TARGET, 32'hffff_ffd8);
        tick(1);
        sp(16'h004e);
        check("ramping", {31'h0, o_ramping}, 32'h0000_0001);
        // error drops the ramp
        i_error <= 1'b1;
        wt(4);
        sp(16'hffd8);
        check("ramping", {31'h0, o_ramping}, 32'h0000_0000);
        i_error <= 1'b0;
        wt(2);
        // hour unit; clearing the error re-seeds from the process value
        apb(1'b1, OFF_UNIT, 32'h0000_0002);
        rd(OFF_UNIT, 32'h0000_0002);
        sp(16'h0064);
        tick(int'(UNIT_HOUR_TICKS) - 1);
        sp(16'h0064);
        tick(1);
        sp(16'h0059);
        end_of_test();
    end
endmodule
